//--- verilog/tcu_pkg.sv
// Purpose: Constants and carrier types for the 16-bit timer compare/capture block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Overview of the rules follows
// Overview of operation
// R1 - New capture overwrites unread captured timestamp
// R2 - Software flips edge, then clears capture flag
// R3 - Compare full counter against compare value always
// R4 - Match sets flag next tick; enable raises irq
// R5 - Flag clears on irq service or one-write
// R6 - Compare A may define counter TOP
// R7 - PWM modes double buffer compare, update at floor
// R8 - CPU reaches buffer or active; hardware never changes
// R9 - High byte read returns stored byte directly; counter and capture high reads return temp
// R10 - High byte to temp, low write moves both
// R11 - Force strobe acts as match, no flag
// R12 - Counter write blocks matches of next tick
// R13 - Counter written at variable TOP runs to FFFF
// R14 - Output state survives waveform mode changes
// R15 - Output action bits apply immediately, unbuffered
// R16 - Reset clears output compare state
// R17 - Nonzero action overrides port value, not direction
// R18 - Action zero leaves output state unchanged
// R19 - Output action bits never affect capture
// R20 - Software reads timestamp early, avoids moving TOP
// R21 - Software presets output state before enabling pin
// R22 - Capture flag set with timestamp copy
// R23 - Mode 4 TOP is compare A, 12 capture
// R24 - Blocked match gives no flag, irq, change
package tcu_pkg;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FORCE = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_CNT_LO = 8'h0c;
  localparam logic [7:0] OFF_CNT_HI = 8'h10;
  localparam logic [7:0] OFF_CMPA_LO = 8'h14;
  localparam logic [7:0] OFF_CMPA_HI = 8'h18;
  localparam logic [7:0] OFF_CMPB_LO = 8'h1c;
  localparam logic [7:0] OFF_CMPB_HI = 8'h20;
  localparam logic [7:0] OFF_CAPT_LO = 8'h24;
  localparam logic [7:0] OFF_CAPT_HI = 8'h28;
  localparam logic [7:0] OFF_PRESCALE = 8'h2c;
  localparam logic [7:0] OFF_PORT = 8'h30;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_IEN_LSB = 8;
  localparam int CTRL_RUN_BIT = 11;
  localparam int CTRL_RISE_BIT = 12;
  // Port register fields
  localparam int PORT_DATA_LSB = 0;
  localparam int PORT_DIR_LSB = 2;
  // Flag bit positions
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_CAPT = 2;

  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hc;
  localparam logic [3:0] MODE_RESERVED = 4'hd;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tcu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcu_apb_rsp_t;

  typedef struct packed {
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } tcu_pins_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [2:0] ien;
    logic run;
    logic capt_rise;
    logic [1:0] port_data;
    logic [1:0] pin_dir;
    logic [7:0] prescale;
    logic [7:0] pre_cnt;
    logic [15:0] cnt;
    logic [7:0] temp;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] capt;
    logic [2:0] flags;
    logic block;
    logic [1:0] oc;
    logic [2:0] sync;
    tcu_pins_t pins;
    logic [2:0] irq;
    tcu_apb_rsp_t rsp;
  } tcu_state_t;

  localparam tcu_state_t STATE_RST = '0;

endpackage

//--- verilog/tcu_timer.sv
// Purpose: Compare units A and B plus capture register of a 16-bit timer
// Assumes: APB master on sys_clk; capture pin asynchronous
// Notes: Single-slope counting; dual-slope sequencing is outside this block
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module tcu_timer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire tcu_pkg::tcu_apb_req_t apb_req,
  output tcu_pkg::tcu_apb_rsp_t apb_rsp,
  input wire logic capt_pin,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq,
  output tcu_pkg::tcu_pins_t pins
);

  // Twelve PWM modes: all but normal, the two clear-on-match modes and reserved
  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = (mode != tcu_pkg::MODE_NORMAL) && (mode != tcu_pkg::MODE_CTC_A) &&
             (mode != tcu_pkg::MODE_CTC_CAPT) && (mode != tcu_pkg::MODE_RESERVED);
  endfunction

  // Modes whose TOP comes from the capture register
  function automatic logic capt_is_top(input logic [3:0] mode);
    capt_is_top = (mode == 4'h8) || (mode == 4'ha) || (mode == tcu_pkg::MODE_CTC_CAPT) ||
                  (mode == 4'he);
  endfunction

  function automatic logic [15:0] top_value(input logic [3:0] mode, input logic [15:0] cmp_a,
                                            input logic [15:0] capt);
    case (mode)
      4'h1, 4'h5: top_value = tcu_pkg::TOP_8BIT;
      4'h2, 4'h6: top_value = tcu_pkg::TOP_9BIT;
      4'h3, 4'h7: top_value = tcu_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_value = cmp_a; // R6 R23
      4'h8, 4'ha, 4'hc, 4'he: top_value = capt; // R23
      default: top_value = tcu_pkg::CNT_MAX;
    endcase
  endfunction

  // Output state after a match (or forced match)
  function automatic logic match_action(input logic oc, input logic [1:0] act, input logic pwm);
    case (act)
      tcu_pkg::ACT_TOGGLE: match_action = pwm ? oc : ~oc;
      tcu_pkg::ACT_CLEAR: match_action = 1'b0;
      tcu_pkg::ACT_SET: match_action = 1'b1;
      default: match_action = oc; // R18
    endcase
  endfunction

  // Output state at the counter floor in PWM modes
  function automatic logic floor_action(input logic oc, input logic [1:0] act);
    case (act)
      tcu_pkg::ACT_CLEAR: floor_action = 1'b1;
      tcu_pkg::ACT_SET: floor_action = 1'b0;
      default: floor_action = oc; // R18
    endcase
  endfunction

  logic rst_ff1_reg;
  logic rst_sync_n_reg;
  tcu_pkg::tcu_state_t state_reg;
  tcu_pkg::tcu_state_t state_next;

  logic tick;
  logic pwm;
  logic [15:0] top;
  logic top_hit;
  logic wrap;
  logic match_a;
  logic match_b;
  logic setup;
  logic wr;
  logic rd;
  logic edge_seen;
  logic [15:0] wval;
  logic [7:0] addr;
  logic [31:0] rdata;
  logic mapped;

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_ff1_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_sync_n_reg <= rst_ff1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    addr = apb_req.paddr;
    pwm = is_pwm(state_reg.mode);
    top = top_value(state_reg.mode, state_reg.cmp_a, state_reg.capt);
    tick = state_reg.run && (state_reg.pre_cnt == state_reg.prescale);
    top_hit = (state_reg.cnt == top) && !state_reg.block; // R13
    wrap = top_hit || (state_reg.cnt == tcu_pkg::CNT_MAX);
    match_a = (state_reg.cnt == state_reg.cmp_a); // R3
    match_b = (state_reg.cnt == state_reg.cmp_b); // R3
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && state_reg.rsp.pready && apb_req.pwrite;
    rd = apb_req.psel && apb_req.penable && state_reg.rsp.pready && !apb_req.pwrite;
    wval = {state_reg.temp, apb_req.pwdata[7:0]};
    edge_seen = state_reg.capt_rise ? (state_reg.sync[1] && !state_reg.sync[2]) :
                (!state_reg.sync[1] && state_reg.sync[2]);

    // Prescaler gives the timer tick
    state_next.pre_cnt = (!state_reg.run || tick) ? 8'h00 : state_reg.pre_cnt + 8'h01;

    // Flag clears first so a same-cycle set wins
    state_next.flags = state_reg.flags & ~irq_ack; // R5
    if (wr && (addr == tcu_pkg::OFF_FLAGS)) begin
      state_next.flags = state_next.flags & ~apb_req.pwdata[2:0]; // R5
    end

    if (tick) begin
      state_next.block = 1'b0;
      state_next.cnt = top_hit ? 16'h0000 : state_reg.cnt + 16'h0001;
      if (match_a && !state_reg.block) begin
        state_next.flags[tcu_pkg::FLAG_A] = 1'b1; // R4 R24
        state_next.oc[0] = match_action(state_reg.oc[0], state_reg.act_a, pwm); // R15 R24
      end
      if (match_b && !state_reg.block) begin
        state_next.flags[tcu_pkg::FLAG_B] = 1'b1; // R4 R24
        state_next.oc[1] = match_action(state_reg.oc[1], state_reg.act_b, pwm); // R15 R24
      end
      if (wrap && pwm) begin
        state_next.cmp_a = state_reg.buf_a; // R7
        state_next.cmp_b = state_reg.buf_b; // R7
        state_next.oc[0] = floor_action(state_next.oc[0], state_reg.act_a);
        state_next.oc[1] = floor_action(state_next.oc[1], state_reg.act_b);
      end
    end

    // Capture: synchroniser then edge; action bits play no part
    state_next.sync = {state_reg.sync[1:0], capt_pin}; // R19
    if (edge_seen && !capt_is_top(state_reg.mode)) begin
      state_next.capt = state_reg.cnt; // R1
      state_next.flags[tcu_pkg::FLAG_CAPT] = 1'b1; // R22
    end

    // Register writes take effect at the completing edge
    if (wr) begin
      case (addr)
        tcu_pkg::OFF_CTRL: begin
          state_next.mode = apb_req.pwdata[tcu_pkg::CTRL_MODE_LSB +: 4]; // R14
          state_next.act_a = apb_req.pwdata[tcu_pkg::CTRL_ACTA_LSB +: 2]; // R15
          state_next.act_b = apb_req.pwdata[tcu_pkg::CTRL_ACTB_LSB +: 2]; // R15
          state_next.ien = apb_req.pwdata[tcu_pkg::CTRL_IEN_LSB +: 3];
          state_next.run = apb_req.pwdata[tcu_pkg::CTRL_RUN_BIT];
          state_next.capt_rise = apb_req.pwdata[tcu_pkg::CTRL_RISE_BIT];
        end
        tcu_pkg::OFF_FORCE: begin
          if (!pwm && apb_req.pwdata[0]) begin
            state_next.oc[0] = match_action(state_next.oc[0], state_reg.act_a, 1'b0); // R11
          end
          if (!pwm && apb_req.pwdata[1]) begin
            state_next.oc[1] = match_action(state_next.oc[1], state_reg.act_b, 1'b0); // R11
          end
        end
        tcu_pkg::OFF_CNT_LO: begin
          state_next.cnt = wval;
          state_next.block = 1'b1; // R12 R13
        end
        tcu_pkg::OFF_CNT_HI, tcu_pkg::OFF_CMPA_HI, tcu_pkg::OFF_CMPB_HI, tcu_pkg::OFF_CAPT_HI: begin
          state_next.temp = apb_req.pwdata[7:0]; // R10
        end
        tcu_pkg::OFF_CMPA_LO: begin
          state_next.buf_a = wval; // R8 R10
          if (!pwm) begin
            state_next.cmp_a = wval; // R7 R8
          end
        end
        tcu_pkg::OFF_CMPB_LO: begin
          state_next.buf_b = wval; // R8 R10
          if (!pwm) begin
            state_next.cmp_b = wval; // R7 R8
          end
        end
        tcu_pkg::OFF_CAPT_LO: begin
          if (capt_is_top(state_reg.mode)) begin
            state_next.capt = wval;
          end
        end
        tcu_pkg::OFF_PRESCALE: begin
          state_next.prescale = apb_req.pwdata[7:0];
        end
        tcu_pkg::OFF_PORT: begin
          state_next.port_data = apb_req.pwdata[tcu_pkg::PORT_DATA_LSB +: 2];
          state_next.pin_dir = apb_req.pwdata[tcu_pkg::PORT_DIR_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Low-byte reads of moving registers latch the high byte
    if (rd && (addr == tcu_pkg::OFF_CNT_LO)) begin
      state_next.temp = state_reg.cnt[15:8];
    end
    if (rd && (addr == tcu_pkg::OFF_CAPT_LO)) begin
      state_next.temp = state_reg.capt[15:8];
    end

    // Read mux, sampled in the setup cycle
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    case (addr)
      tcu_pkg::OFF_CTRL: begin
        rdata[tcu_pkg::CTRL_MODE_LSB +: 4] = state_reg.mode;
        rdata[tcu_pkg::CTRL_ACTA_LSB +: 2] = state_reg.act_a;
        rdata[tcu_pkg::CTRL_ACTB_LSB +: 2] = state_reg.act_b;
        rdata[tcu_pkg::CTRL_IEN_LSB +: 3] = state_reg.ien;
        rdata[tcu_pkg::CTRL_RUN_BIT] = state_reg.run;
        rdata[tcu_pkg::CTRL_RISE_BIT] = state_reg.capt_rise;
      end
      tcu_pkg::OFF_FORCE: rdata[1:0] = state_reg.oc;
      tcu_pkg::OFF_FLAGS: rdata[2:0] = state_reg.flags;
      tcu_pkg::OFF_CNT_LO: rdata[7:0] = state_reg.cnt[7:0];
      tcu_pkg::OFF_CNT_HI: rdata[7:0] = state_reg.temp;
      tcu_pkg::OFF_CMPA_LO: rdata[7:0] = pwm ? state_reg.buf_a[7:0] : state_reg.cmp_a[7:0]; // R8
      tcu_pkg::OFF_CMPA_HI: rdata[7:0] = pwm ? state_reg.buf_a[15:8] : state_reg.cmp_a[15:8]; // R9
      tcu_pkg::OFF_CMPB_LO: rdata[7:0] = pwm ? state_reg.buf_b[7:0] : state_reg.cmp_b[7:0]; // R8
      tcu_pkg::OFF_CMPB_HI: rdata[7:0] = pwm ? state_reg.buf_b[15:8] : state_reg.cmp_b[15:8]; // R9
      tcu_pkg::OFF_CAPT_LO: rdata[7:0] = state_reg.capt[7:0];
      tcu_pkg::OFF_CAPT_HI: rdata[7:0] = state_reg.temp;
      tcu_pkg::OFF_PRESCALE: rdata[7:0] = state_reg.prescale;
      tcu_pkg::OFF_PORT: begin
        rdata[tcu_pkg::PORT_DATA_LSB +: 2] = state_reg.port_data;
        rdata[tcu_pkg::PORT_DIR_LSB +: 2] = state_reg.pin_dir;
      end
      default: mapped = 1'b0;
    endcase

    state_next.rsp.pready = setup;
    state_next.rsp.pslverr = setup && !mapped;
    if (setup) begin
      state_next.rsp.prdata = (apb_req.pwrite || !mapped) ? 32'h0000_0000 : rdata;
    end

    // Registered outputs
    state_next.irq = state_next.flags & state_next.ien; // R4
    state_next.pins.pin_out[0] = (state_next.act_a != tcu_pkg::ACT_NONE) ? state_next.oc[0] :
                                 state_next.port_data[0]; // R17
    state_next.pins.pin_out[1] = (state_next.act_b != tcu_pkg::ACT_NONE) ? state_next.oc[1] :
                                 state_next.port_data[1]; // R17
    state_next.pins.pin_oe = state_next.pin_dir; // R17
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= tcu_pkg::STATE_RST; // R16
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp = state_reg.rsp;
  assign irq = state_reg.irq;
  assign pins = state_reg.pins;

endmodule

`default_nettype wire

//--- bench/tcu_cpu_model.sv
// Purpose: CPU side model that services timer interrupts
// Assumes: svc_en high lets the handler run
// Notes: One acknowledge pulse per pending request
`timescale 1ns/1ps
`default_nettype none
module tcu_cpu_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [2:0] irq,
  input wire logic svc_en,
  output logic [2:0] irq_ack
);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 3'h0;
    end else begin
      irq_ack <= irq & {3{svc_en}} & ~irq_ack;
    end
  end
endmodule
`default_nettype wire

//--- bench/tcu_timer_props.sv
// Purpose: Port level checks of the timer block
// Assumes: One clock domain, raw reset as disable
// Notes: Bound to tcu_timer
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire tcu_pkg::tcu_apb_req_t apb_req,
  input wire tcu_pkg::tcu_apb_rsp_t apb_rsp,
  input wire logic capt_pin,
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq,
  input wire tcu_pkg::tcu_pins_t pins
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_wr(logic [7:0] a);
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == a;
  endsequence
  property p_ready;
    s_setup |=> apb_rsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  property p_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_slverr;
    apb_rsp.pready && (apb_req.paddr > tcu_pkg::OFF_PORT || apb_req.paddr[1:0] != 2'h0) |-> apb_rsp.pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_oe;
    s_wr(tcu_pkg::OFF_PORT) |=> pins.pin_oe == $past(apb_req.pwdata[3:2]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable differs from direction");
  property p_irq_off;
    s_wr(tcu_pkg::OFF_CTRL) ##0 apb_req.pwdata[10:8] == 3'h0 |=> irq == 3'h0;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
  property p_reset;
    $rose(rst_b) |-> pins == '0 && irq == 3'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear in reset");
  property p_ack;
    irq_ack[0] |=> !irq[0];
  endproperty
  a_ack: assert property (p_ack) else $error("serviced flag still pending");
  property p_w1c;
    s_wr(tcu_pkg::OFF_FLAGS) ##0 apb_req.pwdata[2] |=> !irq[2];
  endproperty
  a_w1c: assert property (p_w1c) else $error("capture flag not cleared");
endmodule
bind tcu_timer tcu_timer_props u_tcu_timer_props (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .capt_pin(capt_pin), .irq_ack(irq_ack), .irq(irq), .pins(pins));
`default_nettype wire

//--- bench/timer16_compare_output_units_test.sv
// Purpose: Register level test of the timer compare block
// Assumes: APB answer follows the setup cycle
// Notes: Prescale left at reset value, tick each clock
`timescale 1ns/1ps
`default_nettype none
module timer16_compare_output_units_test;
  logic sys_clk = 1'b0;
  logic rst_b;
  logic capt_pin;
  logic svc_en;
  logic [2:0] irq_ack;
  logic [2:0] irq;
  tcu_pkg::tcu_apb_req_t req;
  tcu_pkg::tcu_apb_rsp_t rsp;
  tcu_pkg::tcu_pins_t pins;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  tcu_timer u_tcu_timer (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .capt_pin(capt_pin), .irq_ack(irq_ack), .irq(irq), .pins(pins));
  tcu_cpu_model u_tcu_cpu_model (.sys_clk(sys_clk), .rst_b(rst_b), .irq(irq), .svc_en(svc_en),
    .irq_ack(irq_ack));
  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      end_sim;
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    chk(name, exp, q);
  endtask
  task wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h04, {24'h0, v[15:8]});
    wr(a, {24'h0, v[7:0]});
  endtask
  task capt_edge(input logic v);
    @(posedge sys_clk);
    capt_pin <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    rst_b = 1'b0;
    req = '0;
    capt_pin = 1'b0;
    svc_en = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("pins", 32'h0, 32'(pins));
    rd("oc", tcu_pkg::OFF_FORCE, 32'h0);
    xfer(1'b0, 8'h3c, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    // Match on A, flag, irq, then service
    wr16(tcu_pkg::OFF_CMPA_LO, 16'h0020);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0000);
    wr(tcu_pkg::OFF_CTRL, 32'h0910);
    n = 0;
    while (irq[0] !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk("irq a", 32'h1, {31'h0, irq[0]});
    wr(tcu_pkg::OFF_CTRL, 32'h0110);
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h1);
    rd("oc", tcu_pkg::OFF_FORCE, 32'h1);
    svc_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    svc_en <= 1'b0;
    chk("irq a", 32'h0, {31'h0, irq[0]});
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h0);
    // Force strobe on A with no action and with toggle
    wr(tcu_pkg::OFF_CTRL, 32'h0000);
    wr(tcu_pkg::OFF_FORCE, 32'h1);
    rd("oc", tcu_pkg::OFF_FORCE, 32'h1);
    wr(tcu_pkg::OFF_CTRL, 32'h0110);
    wr(tcu_pkg::OFF_FORCE, 32'h1);
    rd("oc", tcu_pkg::OFF_FORCE, 32'h0);
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h0);
    wr(tcu_pkg::OFF_CTRL, 32'h0010);
    wr(tcu_pkg::OFF_FORCE, 32'h1);
    wr(tcu_pkg::OFF_PORT, 32'h000e);
    repeat (2) @(posedge sys_clk);
    chk("pins", 32'hf, 32'(pins));
    wr(tcu_pkg::OFF_CTRL, 32'h0015);
    rd("oc", tcu_pkg::OFF_FORCE, 32'h1);
    // Counter write blocks the next match
    wr(tcu_pkg::OFF_CTRL, 32'h0200);
    wr16(tcu_pkg::OFF_CMPB_LO, 16'h0050);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0050);
    wr(tcu_pkg::OFF_CTRL, 32'h0a00);
    repeat (100) @(posedge sys_clk);
    chk("irq b", 32'h0, {31'h0, irq[1]});
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h0);
    // Compare A as TOP
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0000);
    wr(tcu_pkg::OFF_CTRL, 32'h0804);
    repeat (60) @(posedge sys_clk);
    wr(tcu_pkg::OFF_CTRL, 32'h0004);
    xfer(1'b0, tcu_pkg::OFF_CNT_LO, 32'h0, q, e);
    chk("ctc top", 32'h1, {31'h0, q <= 32'h20});
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h1);
    wr(tcu_pkg::OFF_FLAGS, 32'h1);
    // Counter written at variable TOP in PWM
    wr(tcu_pkg::OFF_CTRL, 32'h000f);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0020);
    wr(tcu_pkg::OFF_CTRL, 32'h080f);
    repeat (60) @(posedge sys_clk);
    wr(tcu_pkg::OFF_CTRL, 32'h000f);
    xfer(1'b0, tcu_pkg::OFF_CNT_LO, 32'h0, q, e);
    chk("pwm top", 32'h1, {31'h0, q > 32'h20});
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h2);
    wr(tcu_pkg::OFF_FLAGS, 32'h2);
    // Capture register as TOP
    wr(tcu_pkg::OFF_CTRL, 32'h000c);
    wr16(tcu_pkg::OFF_CAPT_LO, 16'h0010);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0000);
    wr(tcu_pkg::OFF_CTRL, 32'h080c);
    repeat (60) @(posedge sys_clk);
    wr(tcu_pkg::OFF_CTRL, 32'h000c);
    xfer(1'b0, tcu_pkg::OFF_CNT_LO, 32'h0, q, e);
    chk("ctc capt top", 32'h1, {31'h0, q <= 32'h10});
    // Capture overwrite and edge flip
    wr(tcu_pkg::OFF_CTRL, 32'h1400);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0100);
    capt_edge(1'b1);
    capt_edge(1'b0);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0200);
    capt_edge(1'b1);
    chk("irq capt", 32'h1, {31'h0, irq[2]});
    rd("capt lo", tcu_pkg::OFF_CAPT_LO, 32'h0);
    rd("capt hi", tcu_pkg::OFF_CAPT_HI, 32'h2);
    wr(tcu_pkg::OFF_CTRL, 32'h0460);
    wr(tcu_pkg::OFF_FLAGS, 32'h4);
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h0);
    wr16(tcu_pkg::OFF_CNT_LO, 16'h0300);
    capt_edge(1'b0);
    rd("flags", tcu_pkg::OFF_FLAGS, 32'h4);
    rd("capt lo", tcu_pkg::OFF_CAPT_LO, 32'h0);
    rd("capt hi", tcu_pkg::OFF_CAPT_HI, 32'h3);
    // Compare high byte read bypasses temp
    wr16(tcu_pkg::OFF_CMPB_LO, 16'habcd);
    rd("cnt lo", tcu_pkg::OFF_CNT_LO, 32'h0);
    rd("cmp b hi", tcu_pkg::OFF_CMPB_HI, 32'hab);
    rd("cmp b lo", tcu_pkg::OFF_CMPB_LO, 32'hcd);
    end_sim;
  end
endmodule
`default_nettype wire
